// ===== design/atl_pkg.sv
// Package for the front-end test, loopback and power-gating control block.
// Assumes a single 200 MHz clock domain and an Avalon-MM register slave.
package atl_pkg;

   // ****************************************
   // Register map (word indices, byte = 4*idx)
   // ****************************************
   localparam logic [3:0] REG_FE_CTRL_IDX  = 4'h0; // front_end_enable lives here
   localparam logic [3:0] REG_TFC_IDX      = 4'h1; // test_and_frame_control
   localparam logic [3:0] REG_REV_IDX      = 4'h6; // silicon_revision
   localparam logic [3:0] REG_STATUS_IDX   = 4'h8; // block state readback

   // ****************************************
   // Field positions
   // ****************************************
   localparam int BIT_FE_EN    = 7;
   localparam int BIT_TEST_MODE_ENABLE     = 7;
   localparam int BIT_DIGITAL_LOOPBACK_EN    = 6;
   localparam int BIT_ANALOG_LOOPBACK_EN    = 5;
   localparam int BIT_INTERNAL_LOOPBACK_EN    = 4;
   localparam int BIT_CKOUT    = 3;
   localparam int BIT_RXBIAS   = 2;
   localparam int BIT_CFPOS    = 1;
   localparam int BIT_HWFS     = 0;
   localparam int REV_LSB      = 4;

   // ****************************************
   // Reset values
   // ****************************************
   localparam logic [7:0] TFC_RESET    = 8'h00;
   localparam logic [7:0] FE_RESET     = 8'h00;
   localparam logic [3:0] REV_DEFAULT  = 4'h1; // arbitrary value

   // ****************************************
   // Frame timing
   // ****************************************
   localparam logic [15:0] FRAME_PERIOD_DEF = 16'h0100;
   localparam logic [7:0]  CLOCK_OUTPUT_PIN_DIV_DEF   = 8'h04;

   typedef enum logic [1:0] {
      ATL_LOOP_NONE,
      ATL_LOOP_DIG,
      ATL_LOOP_ANA,
      ATL_LOOP_INT
   } atl_loop_t;

   // Control frame offset inside one data-frame interval
   function automatic logic [15:0] atl_cf_offset(input logic [15:0] period,
                                                 input logic        quarter);
      return quarter ? {2'b00, period[15:2]} : {1'b0, period[15:1]};
   endfunction : atl_cf_offset

endpackage : atl_pkg

// ===== design/atl_regs.sv
// Avalon-MM register slave for the control block.
// Assumes a single clock; one wait state on every access.
`timescale 1ns/1ps
`default_nettype none
module atl_regs
   import atl_pkg::*;
(
   // Clock and reset
   input  wire  logic        clk,
   input  wire  logic        rst_n,
   // Avalon-MM slave
   input  wire  logic [5:0]  avs_address,
   input  wire  logic        avs_read,
   input  wire  logic        avs_write,
   input  wire  logic [31:0] avs_writedata,
   input  wire  logic [3:0]  avs_byteenable,
   output logic [31:0]       avs_readdata,
   output logic              avs_waitrequest,
   // Register contents and state
   output logic [7:0]        fe_ctrl_q,
   output logic [7:0]        tfc_q,
   input  wire  logic [3:0]  revision,
   input  wire  logic [7:0]  status
);

   logic       ack_q;
   logic [3:0] idx;
   logic       wr_ok;

   assign idx             = avs_address[5:2];
   assign avs_waitrequest = (avs_read | avs_write) & ~ack_q;
   // Write lands on the edge that ends the wait state, as the master sees it
   assign wr_ok           = avs_write & ack_q & avs_byteenable[0];

   // ****************************************
   // Handshake
   // ****************************************
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         ack_q <= 1'b0;
      end else begin
         ack_q <= (avs_read | avs_write) & ~ack_q;
      end
   end

   // ****************************************
   // Writes, accepted in any power state
   // ****************************************
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         tfc_q     <= TFC_RESET;
         fe_ctrl_q <= FE_RESET;
      end else if (wr_ok) begin
         if (idx == REG_TFC_IDX) begin
            tfc_q <= avs_writedata[7:0];
         end
         if (idx == REG_FE_CTRL_IDX) begin
            fe_ctrl_q <= avs_writedata[7:0];
         end
      end
   end

   // ****************************************
   // Reads; unmapped words read as zero
   // ****************************************
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         avs_readdata <= 32'h0000_0000;
      end else if (avs_read & ~ack_q) begin
         case (idx)
            REG_FE_CTRL_IDX: avs_readdata <= {24'h00_0000, fe_ctrl_q};
            REG_TFC_IDX:     avs_readdata <= {24'h00_0000, tfc_q};
            REG_REV_IDX:     avs_readdata <= {24'h00_0000, revision, 4'h0};
            REG_STATUS_IDX:  avs_readdata <= {24'h00_0000, status};
            default:         avs_readdata <= 32'h0000_0000;
         endcase
      end
   end

endmodule : atl_regs
`default_nettype wire

// ===== design/atl_framer.sv
// Frame-sync and control-frame scheduler.
// Assumes the serial side presents one bit-0 sample per data frame.
`timescale 1ns/1ps
`default_nettype none
module atl_framer
   import atl_pkg::*;
(
   // Clock and reset
   input  wire  logic        clk,
   input  wire  logic        rst_n,
   // Configuration
   input  wire  logic        hw_mode,
   input  wire  logic        quarter_pos,
   input  wire  logic [15:0] period,
   // Software frame sync and frame data
   input  wire  logic        sw_frame_sync,
   input  wire  logic        frame_bit0,
   // Results
   output logic              frame_sync,
   output logic              data_frame_start,
   output logic              control_frame_start,
   output logic              tx_word_bit0
);

   logic [15:0] cnt_q;
   logic        pending_q;
   logic        hw_tick;

   assign hw_tick = (cnt_q == 16'h0000);
   // Hardware mode makes its own sync, otherwise software drives it
   assign data_frame_start = hw_mode ? hw_tick : sw_frame_sync;

   // ****************************************
   // Interval counter
   // ****************************************
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         cnt_q <= 16'h0000;
      end else if (data_frame_start || cnt_q >= period - 16'h0001) begin
         cnt_q <= hw_mode && !data_frame_start ? 16'h0000 : 16'h0001;
      end else begin
         cnt_q <= cnt_q + 16'h0001;
      end
   end

   // ****************************************
   // Control frame request and placement
   // ****************************************
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         pending_q    <= 1'b0;
         tx_word_bit0 <= 1'b0;
      end else if (data_frame_start) begin
         // Bit 0 is data in hardware mode, a request in software mode
         pending_q    <= hw_mode | frame_bit0;
         tx_word_bit0 <= hw_mode & frame_bit0;
      end else if (control_frame_start) begin
         pending_q <= 1'b0;
      end
   end

   assign control_frame_start = pending_q &&
      (cnt_q == atl_cf_offset(period, quarter_pos));

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         frame_sync <= 1'b0;
      end else begin
         frame_sync <= data_frame_start | control_frame_start;
      end
   end

endmodule : atl_framer
`default_nettype wire

// ===== design/atl_top.sv
// Front-end test, loopback routing and power gating control.
// Assumes one 200 MHz clock and an Avalon-MM master for software access.
`timescale 1ns/1ps
`default_nettype none
module atl_top
   import atl_pkg::*;
#(
   parameter logic [3:0] REVISION = REV_DEFAULT, // arbitrary value
   parameter logic [7:0] CLOCK_OUTPUT_PIN_DIV = CLOCK_OUTPUT_PIN_DIV_DEF
)(
   // Clock and reset
   input  wire  logic        clk,
   input  wire  logic        rst_n,
   // Avalon-MM slave
   input  wire  logic [5:0]  avs_address,
   input  wire  logic        avs_read,
   input  wire  logic        avs_write,
   input  wire  logic [31:0] avs_writedata,
   input  wire  logic [3:0]  avs_byteenable,
   output logic [31:0]       avs_readdata,
   output logic              avs_waitrequest,
   // Frame interface
   input  wire  logic [15:0] frame_period,
   input  wire  logic        sw_frame_sync,
   input  wire  logic        serial_data_in_bit0,
   output logic              frame_sync,
   output logic              control_frame_start,
   output logic              tx_word_bit0,
   // Digital paths
   input  wire  logic        tx_sigma_delta_modulator,
   input  wire  logic        rx_adc_bit,
   input  wire  logic        rx_path_bit_ext,
   output logic              sinc3_in,
   output logic              tx_dac_in,
   // Analog switch controls
   output logic              ana_loop_switch,
   output logic              receive_bias_en,
   output logic              tx_out_hiz,
   // Clock gating
   output logic              filter_clk_en,
   output logic              analog_clk_en,
   output logic              port_clk_en,
   // Test clock output pin
   output logic              clock_output_pin_o,
   output logic              clock_output_pin_oe
);

   logic [7:0] fe_ctrl_q;
   logic [7:0] tfc_q;
   logic [7:0] status;
   logic       test_mode_enable;
   logic       front_end_enable;
   logic       digital_loopback_en;
   logic       analog_loopback_en;
   logic       internal_loopback_en;
   logic       clock_output_enable;
   logic [7:0] div_q;
   logic       clk_tgl_q;
   logic       data_frame_start;
   logic       cf_start;

   // ****************************************
   // Registers
   // ****************************************
   atl_regs u_regs (
      .clk             (clk),
      .rst_n           (rst_n),
      .avs_address     (avs_address),
      .avs_read        (avs_read),
      .avs_write       (avs_write),
      .avs_writedata   (avs_writedata),
      .avs_byteenable  (avs_byteenable),
      .avs_readdata    (avs_readdata),
      .avs_waitrequest (avs_waitrequest),
      .fe_ctrl_q       (fe_ctrl_q),
      .tfc_q           (tfc_q),
      .revision        (REVISION),
      .status          (status)
   );

   // ****************************************
   // Field decode
   // ****************************************
   assign test_mode_enable     = tfc_q[BIT_TEST_MODE_ENABLE];
   assign front_end_enable     = fe_ctrl_q[BIT_FE_EN];
   // Loopbacks are inert unless test modes are on
   assign digital_loopback_en  = test_mode_enable & tfc_q[BIT_DIGITAL_LOOPBACK_EN];
   assign analog_loopback_en   = test_mode_enable & tfc_q[BIT_ANALOG_LOOPBACK_EN];
   assign internal_loopback_en = test_mode_enable & tfc_q[BIT_INTERNAL_LOOPBACK_EN];
   assign clock_output_enable  = test_mode_enable & tfc_q[BIT_CKOUT];

   // ****************************************
   // Loopback routing
   // ****************************************
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         sinc3_in  <= 1'b0;
         tx_dac_in <= 1'b0;
      end else begin
         sinc3_in  <= digital_loopback_en ? tx_sigma_delta_modulator
                                          : rx_adc_bit;
         tx_dac_in <= internal_loopback_en ? rx_adc_bit
                                           : tx_sigma_delta_modulator;
      end
   end

   // Analog switches are level controls, registered to avoid glitches
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         ana_loop_switch <= 1'b0;
         receive_bias_en <= 1'b0;
         tx_out_hiz      <= 1'b1;
      end else begin
         ana_loop_switch <= analog_loopback_en;
         receive_bias_en <= test_mode_enable & tfc_q[BIT_RXBIAS];
         tx_out_hiz      <= ~front_end_enable;
      end
   end

   // ****************************************
   // Clock gating; port clock never stops
   // ****************************************
   assign filter_clk_en = front_end_enable;
   assign analog_clk_en = front_end_enable;
   assign port_clk_en   = 1'b1;

   // ****************************************
   // Test clock output, divided from clk
   // ****************************************
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         div_q     <= 8'h00;
         clk_tgl_q <= 1'b0;
      end else if (div_q >= CLOCK_OUTPUT_PIN_DIV - 8'h01) begin
         div_q     <= 8'h00;
         clk_tgl_q <= ~clk_tgl_q;
      end else begin
         div_q <= div_q + 8'h01;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         clock_output_pin_o  <= 1'b0;
         clock_output_pin_oe <= 1'b0;
      end else begin
         clock_output_pin_o  <= clk_tgl_q & clock_output_enable;
         clock_output_pin_oe <= clock_output_enable;
      end
   end

   // ****************************************
   // Framing, runs regardless of the front end enable
   // ****************************************
   atl_framer u_framer (
      .clk                 (clk),
      .rst_n               (rst_n),
      .hw_mode             (tfc_q[BIT_HWFS]),
      .quarter_pos         (tfc_q[BIT_CFPOS]),
      .period              (frame_period),
      .sw_frame_sync       (sw_frame_sync),
      .frame_bit0          (serial_data_in_bit0),
      .frame_sync          (frame_sync),
      .data_frame_start    (data_frame_start),
      .control_frame_start (cf_start),
      .tx_word_bit0        (tx_word_bit0)
   );

   assign control_frame_start = cf_start;

   assign status = {front_end_enable, digital_loopback_en,
                    analog_loopback_en, internal_loopback_en,
                    clock_output_enable, receive_bias_en,
                    data_frame_start, cf_start};

endmodule : atl_top
`default_nettype wire

// ===== dv/atl_top_props.sv
// Checker for atl_top: register shadow and port relations.
// Assumes it is bound into atl_top and sees only its ports.
`timescale 1ns/1ps
`default_nettype none
module atl_top_props
   import atl_pkg::*;
#(
   parameter logic [3:0] REVISION = REV_DEFAULT
)(
   // Clock, reset and bus
   input wire logic        clk,
   input wire logic        rst_n,
   input wire logic [5:0]  avs_address,
   input wire logic        avs_read,
   input wire logic        avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0]  avs_byteenable,
   input wire logic [31:0] avs_readdata,
   input wire logic        avs_waitrequest,
   // Frame side
   input wire logic        sw_frame_sync,
   input wire logic        serial_data_in_bit0,
   input wire logic        frame_sync,
   input wire logic        control_frame_start,
   // Paths and controls
   input wire logic        tx_sigma_delta_modulator,
   input wire logic        rx_adc_bit,
   input wire logic        sinc3_in,
   input wire logic        tx_dac_in,
   input wire logic        ana_loop_switch,
   input wire logic        receive_bias_en,
   input wire logic        clock_output_pin_oe,
   input wire logic        filter_clk_en,
   input wire logic        port_clk_en
);
   // ****************************************
   // Shadow of the writable state
   // ****************************************
   logic [7:0] tfc_q;
   logic       fe_q;
   logic       req_q;
   logic [7:0] sw_age_q;
   logic [3:0] idx;
   logic       done_wr;
   logic       done_rd;
   assign idx = avs_address[5:2];
   assign done_wr = avs_write && !avs_waitrequest && avs_byteenable[0];
   assign done_rd = avs_read && !avs_waitrequest;

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         tfc_q <= 8'h00;
         fe_q  <= 1'b0;
      end else if (done_wr) begin
         if (idx == 4'h1) tfc_q <= avs_writedata[7:0];
         if (idx == 4'h0) fe_q <= avs_writedata[7];
      end
   end
   // Age of software mode, so stale hardware frames are not judged
   always_ff @(posedge clk) begin
      if (!rst_n || tfc_q[0]) sw_age_q <= 8'h00;
      else if (sw_age_q != 8'hFF) sw_age_q <= sw_age_q + 8'h01;
   end
   // A new request wins over the frame that consumes the old one
   always_ff @(posedge clk) begin
      if (!rst_n) req_q <= 1'b0;
      else if (sw_frame_sync && serial_data_in_bit0) req_q <= 1'b1;
      else if (control_frame_start) req_q <= 1'b0;
   end

   a_one_wait: assert property (@(posedge clk) disable iff (!rst_n)
      $rose(avs_read || avs_write) |-> avs_waitrequest ##1 !avs_waitrequest)
      else $error("bus access did not take one wait state");
   a_rev_read: assert property (@(posedge clk) disable iff (!rst_n)
      done_rd && idx == 4'h6 |-> avs_readdata == {24'h0, REVISION, 4'h0})
      else $error("revision readback wrong");
   a_ctrl_read: assert property (@(posedge clk) disable iff (!rst_n)
      done_rd && idx == 4'h1 |-> avs_readdata == {24'h0, tfc_q})
      else $error("control register readback wrong");
   a_dig_route: assert property (@(posedge clk) disable iff (!rst_n)
      $past(tfc_q[7] && tfc_q[6]) |-> sinc3_in == $past(tx_sigma_delta_modulator))
      else $error("digital loopback stream not routed");
   a_int_route: assert property (@(posedge clk) disable iff (!rst_n)
      $past(tfc_q[7] && tfc_q[4]) |-> tx_dac_in == $past(rx_adc_bit))
      else $error("internal loopback stream not routed");
   a_test_gating: assert property (@(posedge clk) disable iff (!rst_n)
      {ana_loop_switch, receive_bias_en, clock_output_pin_oe} == $past({
      tfc_q[7] & tfc_q[5], tfc_q[7] & tfc_q[2], tfc_q[7] & tfc_q[3]}))
      else $error("test controls do not follow the register");
   a_fe_gating: assert property (@(posedge clk) disable iff (!rst_n)
      filter_clk_en == fe_q && port_clk_en)
      else $error("clock gating does not follow front-end enable");
   a_cf_request: assert property (@(posedge clk) disable iff (!rst_n)
      control_frame_start && sw_age_q == 8'hFF |-> req_q)
      else $error("control frame without a request");
   a_cf_sync: assert property (@(posedge clk) disable iff (!rst_n)
      control_frame_start |=> frame_sync)
      else $error("no frame sync after control frame");
endmodule : atl_top_props
`default_nettype wire

// ===== dv/atl_host_model.sv
// Host serial port model: software frame sync with request bit.
// Assumes the bench sets run and offers a request level each cycle.
`timescale 1ns/1ps
`default_nettype none
module atl_host_model #(
   parameter int GAP = 40
)(
   // Clock, reset, control
   input  wire logic       clk,
   input  wire logic       rst_n,
   input  wire logic       run,
   input  wire logic       req,
   // Serial side
   output logic            sw_frame_sync,
   output logic            serial_data_in_bit0,
   output logic [7:0]      req_count
);
   int cnt;
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         cnt <= 0;
         sw_frame_sync <= 1'b0;
         serial_data_in_bit0 <= 1'b0;
         req_count <= 8'h00;
      end else begin
         cnt <= (cnt == GAP - 1) ? 0 : cnt + 1;
         sw_frame_sync <= run && cnt == GAP - 1;
         if (run && cnt == GAP - 1) begin
            serial_data_in_bit0 <= req;
            req_count <= req_count + 8'(req);
         end else begin
            // Outside frames the line shows no stale value
            serial_data_in_bit0 <= ~serial_data_in_bit0;
         end
      end
   end
endmodule : atl_host_model
`default_nettype wire

// ===== dv/atl_top_tb.sv
// Testbench for atl_top: registers, routing levels and frame timing.
// Assumes the design files, the host model and the checker.
`timescale 1ns/1ps
`default_nettype none
module atl_top_tb
   import atl_pkg::*;
;
   localparam logic [3:0] REV = 4'hA; // arbitrary value
   logic        clk, rst_n, avs_read, avs_write, avs_waitrequest;
   logic [5:0]  avs_address;
   logic [31:0] avs_writedata, avs_readdata, rd;
   logic [3:0]  avs_byteenable;
   logic [15:0] frame_period;
   logic        sw_frame_sync, serial_data_in_bit0, frame_sync, run, req, f;
   logic        control_frame_start, tx_sigma_delta_modulator, rx_adc_bit;
   logic        ana_loop_switch, receive_bias_en, clock_output_pin_oe;
   logic        filter_clk_en, analog_clk_en, port_clk_en;
   logic [7:0]  req_count, v;
   logic        tx_out_hiz, ck_o, tx_word_bit0;
   logic [1:0]  tw;
   int          num_errors, num_checks, seed, cyc, ncf, n, fs_at, p, b_cf, b_rq;

   atl_top #(.REVISION(REV)) dut (.clk(clk), .rst_n(rst_n),
      .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
      .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
      .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
      .frame_period(frame_period), .sw_frame_sync(sw_frame_sync),
      .serial_data_in_bit0(serial_data_in_bit0), .frame_sync(frame_sync),
      .control_frame_start(control_frame_start), .tx_word_bit0(tx_word_bit0),
      .tx_sigma_delta_modulator(tx_sigma_delta_modulator),
      .rx_adc_bit(rx_adc_bit), .rx_path_bit_ext(1'b0), .sinc3_in(),
      .tx_dac_in(), .ana_loop_switch(ana_loop_switch),
      .tx_out_hiz(tx_out_hiz),
      .receive_bias_en(receive_bias_en), .filter_clk_en(filter_clk_en),
      .analog_clk_en(analog_clk_en), .port_clk_en(port_clk_en),
      .clock_output_pin_o(ck_o), .clock_output_pin_oe(clock_output_pin_oe));
   atl_host_model #(.GAP(40)) host (.clk(clk), .rst_n(rst_n), .run(run),
      .req(req), .sw_frame_sync(sw_frame_sync),
      .serial_data_in_bit0(serial_data_in_bit0), .req_count(req_count));

   // ****************************************
   // Clock, random streams, timeout
   // ****************************************
   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end
   always @(posedge clk) begin
      // Bit streams only, no code words beyond a quarter scale
      {tx_sigma_delta_modulator, rx_adc_bit, req} <= 3'($random(seed));
      cyc <= cyc + 1;
      if (cyc == 8000) begin
         num_errors++;
         finish_test();
      end
   end
   always @(negedge clk) if (control_frame_start === 1'b1) ncf++;

   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         num_errors++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : check
   // Request held until waitrequest is seen low at a rising edge
   task automatic bus(input logic wr, input logic [3:0] idx,
                      input logic [7:0] wd, input logic [3:0] be);
      @(posedge clk);
      avs_address <= {idx, 2'b00};
      avs_read <= !wr;
      avs_write <= wr;
      avs_writedata <= {24'h0, wd};
      avs_byteenable <= be;
      do begin
         @(posedge clk);
      end while (avs_waitrequest !== 1'b0);
      rd = avs_readdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
   endtask : bus
   task automatic rd_chk(input logic [3:0] idx, input logic [31:0] exp);
      bus(1'b0, idx, 8'h00, 4'hF);
      check(rd, exp);
   endtask : rd_chk
   task automatic wait_cf();
      logic b0;
      b0 = 1'b0;
      n = 0;
      fs_at = 0;
      do begin
         @(negedge clk);
         n++;
         if (frame_sync === 1'b1 && n > 1) begin
            fs_at = n;
            // Word bit 0 against the line level at the data frame
            tw = {tx_word_bit0, b0};
         end
         b0 = serial_data_in_bit0;
      end while (control_frame_start !== 1'b1);
   endtask : wait_cf
   function automatic logic [5:0] exp_lv(input int t, input int fe);
      int m;
      m = (t >> 7) & 1;
      return {1'(m & (t >> 5)), 1'(m & (t >> 2)), 1'(m & (t >> 3)),
              1'(fe), 1'(fe), 1'b1};
   endfunction : exp_lv
   task automatic finish_test();
      $display("checks=%0d errors=%0d", num_checks, num_errors);
      if (num_errors == 0 && num_checks > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask : finish_test

   // ****************************************
   // Main sequence
   // ****************************************
   initial begin
      {rst_n, avs_read, avs_write, run, req} = 5'h00;
      {tx_sigma_delta_modulator, rx_adc_bit} = 2'b00;
      avs_address = 6'h00;
      avs_writedata = 32'h0;
      avs_byteenable = 4'h0;
      frame_period = 16'h0010;
      {num_errors, num_checks, cyc, ncf} = {32'h0, 32'h0, 32'h0, 32'h0};
      seed = 32'h12AE;
      repeat (3) @(posedge clk);
      rst_n <= 1'b1;
      rd_chk(4'h1, 32'h0);
      rd_chk(4'h6, {24'h0, REV, 4'h0});
      rd_chk(4'h3, 32'h0);
      rd_chk(4'h8, 32'h0);
      // Write without byte lane 0 enabled leaves the register unchanged
      bus(1'b1, 4'h1, 8'hFF, 4'hE);
      rd_chk(4'h1, 32'h0);
      for (int i = 0; i < 24; i++) begin
         v = 8'($random(seed));
         f = 1'($random(seed));
         bus(1'b1, 4'h1, v, 4'h1);
         bus(1'b1, 4'h0, {f, 7'h00}, 4'h1);
         rd_chk(4'h1, {24'h0, v});
         @(negedge clk);
         check(32'({ana_loop_switch, receive_bias_en, clock_output_pin_oe,
            filter_clk_en, analog_clk_en, port_clk_en}), 32'(exp_lv(v, f)));
         check(32'(tx_out_hiz), 32'(!f));
         check(32'(ck_o & !(v[7] & v[3])), 32'h0);
      end
      for (int pos = 0; pos < 2; pos++) begin
         p = 20 + 8 * pos;
         frame_period <= 16'(p);
         bus(1'b1, 4'h1, 8'(1 + 2 * pos), 4'h1);
         wait_cf();
         wait_cf();
         wait_cf();
         check(32'(n), 32'(p));
         check(32'(fs_at), 32'(p - (pos == 1 ? p / 4 : p / 2) + 1));
         check(32'(tw[1]), 32'(tw[0]));
      end
      bus(1'b1, 4'h1, 8'h00, 4'h1);
      repeat (300) @(posedge clk);
      b_cf = ncf;
      b_rq = int'(req_count);
      run <= 1'b1;
      repeat (600) @(posedge clk);
      run <= 1'b0;
      repeat (100) @(posedge clk);
      check(32'(ncf - b_cf), 32'(int'(req_count) - b_rq));
      finish_test();
   end
endmodule : atl_top_tb

bind atl_top atl_top_props #(.REVISION(REVISION)) u_props (.clk(clk),
   .rst_n(rst_n), .avs_address(avs_address), .avs_read(avs_read),
   .avs_write(avs_write), .avs_writedata(avs_writedata),
   .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
   .avs_waitrequest(avs_waitrequest), .sw_frame_sync(sw_frame_sync),
   .serial_data_in_bit0(serial_data_in_bit0), .frame_sync(frame_sync),
   .control_frame_start(control_frame_start), .rx_adc_bit(rx_adc_bit),
   .tx_sigma_delta_modulator(tx_sigma_delta_modulator),
   .sinc3_in(sinc3_in), .tx_dac_in(tx_dac_in),
   .ana_loop_switch(ana_loop_switch), .receive_bias_en(receive_bias_en),
   .clock_output_pin_oe(clock_output_pin_oe),
   .filter_clk_en(filter_clk_en), .port_clk_en(port_clk_en));
`default_nettype wire
